// [common/eeprom_link_if.sv]
`timescale 1ns/100ps
interface eeprom_link_if;
	logic scl;
	logic sda;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;

	// Open-drain data wire: low while either end pulls, else pulled up
	assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

	modport device (input scl, input sda, output s_sda_o, output s_sda_oe);
	modport host (output scl, input sda, output m_sda_o, output m_sda_oe);
endinterface : eeprom_link_if

// [common/eeprom_pkg.sv]
package eeprom_pkg;

	// Device side: which byte of the command comes next
	typedef enum logic [2:0] {
		dev_idle, dev_ctrl, dev_adh, dev_adl, dev_wdat, dev_rdat
	} dev_state_t;

	// Host side: bus condition or byte being moved
	typedef enum logic [3:0] {
		h_idle, h_start, h_ctrl, h_ah, h_al, h_load, h_wr, h_rctrl, h_rd, h_stop
	} host_state_t;

endpackage : eeprom_pkg

// [common/eeprom_regs.svh]
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

// Device-type code carried in the upper control-byte nibble
`define EE_TYPE_CODE 4'hA
// Word address width and page geometry
`define EE_ADDR_W 15
`define EE_PAGE_BYTES 64
`define EE_PAGE_W 6
// Bit index of the acknowledge clock within a byte
`define EE_ACK_BIT 4'h8
// System clock period and write-cycle time, both in ns
`define EE_CLK_NS 40
`define EE_WR_TIME_NS 5000000
// Longest time, so the count rounds down
`define EE_WR_CYCLES (`EE_WR_TIME_NS / `EE_CLK_NS)
// System clocks per quarter of a serial clock period
`define EE_SCL_QTR 3
// Control bytes sent while polling before giving up
`define EE_POLL_MAX 200
// Depth of the host write-data FIFO
`define EE_FIFO_DEPTH 8

`endif

// [logic/byte_fifo.sv]
`timescale 1ns/100ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic room_q;
	logic push;
	logic pop;

	assign push = in_valid && room_q;
	assign pop = out_valid && out_ready;
	assign in_ready = room_q;
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rp_q];

	// Occupancy; full is registered so the ready seen upstream is a flop
	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) cnt_d = cnt_q + 1'b1;
		if (pop && !push) cnt_d = cnt_q - 1'b1;
	end

	// Pointers wrap at DEPTH, which need not be a power of two
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			room_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			room_q <= (cnt_d != (AW+1)'(DEPTH));
			if (push) wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
			if (pop) rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
		end
	end

	// Storage needs no reset
	always_ff @(posedge clk_sys) begin
		if (push) mem_q[wp_q] <= in_data;
	end
endmodule : byte_fifo

// [logic/eeprom_device.sv]
`timescale 1ns/100ps
`include "eeprom_regs.svh"
module eeprom_device
	import eeprom_pkg::*;
#(
	parameter int WR_CYCLES = `EE_WR_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	eeprom_link_if.device link,
	input wire logic select_pin_low,
	input wire logic select_pin_mid,
	input wire logic select_pin_high,
	input wire logic write_protect,
	output logic write_busy
);
	localparam int MEM_WORDS = 1 << `EE_ADDR_W;

	logic [7:0] mem [MEM_WORDS];
	logic [7:0] pbuf [`EE_PAGE_BYTES];

	logic [5:0] sync1_q;
	logic [5:0] sync2_q;
	logic scl_p_q;
	logic sda_p_q;
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic [2:0] sel_s;

	dev_state_t st_q;
	logic [3:0] bitn_q;
	logic ackph_q;
	logic [7:0] sh_q;
	logic [`EE_ADDR_W-1:0] ptr_q;
	logic sda_oe_q;
	logic got_q;

	logic [`EE_PAGE_BYTES-1:0] touched_q;
	logic busy_q;
	logic cmt_q;
	logic [`EE_PAGE_W-1:0] idx_q;
	logic [`EE_ADDR_W-`EE_PAGE_W-1:0] page_q;
	logic [31:0] tmr_q;

	logic start_ev;
	logic stop_ev;
	logic scl_rise;
	logic scl_fall;
	logic byte_done;
	logic ctrl_hit;
	logic wr_go;
	logic [7:0] mem_rd;

	// Bus pins and straps all come from outside this clock
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= 6'h3F;
			sync2_q <= 6'h3F;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			sync1_q <= {write_protect, select_pin_high, select_pin_mid,
				select_pin_low, link.sda, link.scl};
			sync2_q <= sync1_q;
			scl_p_q <= sync2_q[0];
			sda_p_q <= sync2_q[1];
		end
	end

	assign scl_s = sync2_q[0];
	assign sda_s = sync2_q[1];
	assign sel_s = sync2_q[4:2];
	assign wp_s = sync2_q[5];

	// Data moving while the clock is high marks Start or Stop
	assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign stop_ev = scl_s && scl_p_q && !sda_p_q && sda_s;
	assign scl_rise = scl_s && !scl_p_q;
	assign scl_fall = !scl_s && scl_p_q;
	assign byte_done = scl_fall && (bitn_q == `EE_ACK_BIT) && !ackph_q;

	// Busy also blocks the ack, which is what the host polls on
	assign ctrl_hit = (sh_q[7:4] == `EE_TYPE_CODE) && (sh_q[3:1] == sel_s) && !busy_q;

	// Commit only a write that got data and is not protected
	assign wr_go = stop_ev && (st_q == dev_wdat) && got_q && !wp_s;

	assign mem_rd = mem[ptr_q];
	assign link.s_sda_o = 1'b0;
	assign link.s_sda_oe = sda_oe_q;
	assign write_busy = busy_q;

	// Command sequencer; data changes only on clock falls
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= dev_idle;
			bitn_q <= 4'h0;
			ackph_q <= 1'b0;
			sh_q <= 8'h00;
			ptr_q <= '0;
			sda_oe_q <= 1'b0;
			got_q <= 1'b0;
		end else if (start_ev) begin
			// Repeated Start drops any pending write data
			st_q <= dev_ctrl;
			bitn_q <= 4'h0;
			ackph_q <= 1'b0;
			sda_oe_q <= 1'b0;
			got_q <= 1'b0;
		end else if (stop_ev) begin
			st_q <= dev_idle;
			ackph_q <= 1'b0;
			sda_oe_q <= 1'b0;
			got_q <= 1'b0;
		end else if (st_q != dev_idle) begin
			if (scl_rise && !ackph_q && (bitn_q != `EE_ACK_BIT)) begin
				sh_q <= {sh_q[6:0], sda_s};
				bitn_q <= bitn_q + 4'h1;
			end else if (scl_rise && ackph_q && (st_q == dev_rdat) && sda_s) begin
				// Host left the byte unacknowledged; line already free
				st_q <= dev_idle;
			end else if (byte_done) begin
				ackph_q <= 1'b1;
				sda_oe_q <= 1'b1;
				case (st_q)
					dev_ctrl: begin
						if (!ctrl_hit) begin
							st_q <= dev_idle;
							ackph_q <= 1'b0;
							sda_oe_q <= 1'b0;
						end else if (sh_q[0]) begin
							st_q <= dev_rdat;
						end else begin
							st_q <= dev_adh;
						end
					end
					dev_adh: begin
						ptr_q[14:8] <= sh_q[6:0];
						st_q <= dev_adl;
					end
					dev_adl: begin
						ptr_q[7:0] <= sh_q;
						st_q <= dev_wdat;
					end
					dev_wdat: begin
						ptr_q[5:0] <= ptr_q[5:0] + 6'h01;
						got_q <= 1'b1;
					end
					dev_rdat: begin
						// Byte sent: free the line for the host's answer
						sda_oe_q <= 1'b0;
						ptr_q <= ptr_q + 15'h0001;
					end
					default: begin
						st_q <= dev_idle;
					end
				endcase
			end else if (scl_fall && ackph_q) begin
				ackph_q <= 1'b0;
				bitn_q <= 4'h0;
				if (st_q == dev_rdat) begin
					sh_q <= mem_rd;
					sda_oe_q <= !mem_rd[7];
				end else begin
					sda_oe_q <= 1'b0;
				end
			end else if (scl_fall && (st_q == dev_rdat)) begin
				sda_oe_q <= !sh_q[7];
			end
		end
	end

	// Bytes written this command; cleared when the address is loaded
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			touched_q <= '0;
		end else if (byte_done && (st_q == dev_adl)) begin
			touched_q <= '0;
		end else if (byte_done && (st_q == dev_wdat)) begin
			touched_q[ptr_q[5:0]] <= 1'b1;
		end
	end

	// Self-timed write: copy the page, then wait out the write time
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			busy_q <= 1'b0;
			cmt_q <= 1'b0;
			idx_q <= '0;
			page_q <= '0;
			tmr_q <= 32'h0;
		end else if (wr_go) begin
			busy_q <= 1'b1;
			cmt_q <= 1'b1;
			idx_q <= '0;
			page_q <= ptr_q[14:6];
			tmr_q <= 32'h0;
		end else if (cmt_q) begin
			idx_q <= idx_q + 6'h01;
			if (idx_q == 6'h3F) cmt_q <= 1'b0;
		end else if (busy_q) begin
			tmr_q <= tmr_q + 32'h1;
			if (tmr_q >= 32'(WR_CYCLES - 1)) busy_q <= 1'b0;
		end
	end

	// Page buffer and array; untouched bytes are rewritten as they stand
	always_ff @(posedge clk_sys) begin
		if (byte_done && (st_q == dev_wdat)) begin
			pbuf[ptr_q[5:0]] <= sh_q;
		end
		if (cmt_q) begin
			mem[{page_q, idx_q}] <= touched_q[idx_q] ? pbuf[idx_q] : mem[{page_q, idx_q}];
		end
	end
endmodule : eeprom_device

// [logic/eeprom_host.sv]
`timescale 1ns/100ps
`include "eeprom_regs.svh"
module eeprom_host
	import eeprom_pkg::*;
#(
	parameter int SCL_QTR = `EE_SCL_QTR,
	parameter int POLL_MAX = `EE_POLL_MAX,
	parameter int FIFO_DEPTH = `EE_FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	eeprom_link_if.host link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_read,
	input wire logic cmd_current,
	input wire logic [2:0] cmd_dev,
	input wire logic [14:0] cmd_addr,
	input wire logic [6:0] cmd_len,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [7:0] wr_data,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic done,
	output logic fail
);
	host_state_t st_q;
	logic [7:0] div_q;
	logic tick;
	logic s1_q;
	logic s2_q;
	logic [1:0] q_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic [6:0] left_q;
	logic [6:0] room;
	logic rdph_q;
	logic [7:0] poll_q;
	logic scl_q;
	logic oe_q;
	logic [2:0] dev_q;
	logic [14:0] addr_q;
	logic rdy_q;
	logic rdv_q;
	logic [7:0] rdd_q;
	logic done_q;
	logic fail_q;
	logic f_valid;
	logic [7:0] f_data;
	logic rd_cmd_q;

	// Write data waits here; a full FIFO stalls the user
	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(wr_data),
		.out_valid(f_valid),
		.out_ready(st_q == h_load),
		.out_data(f_data)
	);

	assign link.scl = scl_q;
	assign link.m_sda_o = 1'b0;
	assign link.m_sda_oe = oe_q;
	assign cmd_ready = rdy_q;
	assign rd_valid = rdv_q;
	assign rd_data = rdd_q;
	assign done = done_q;
	assign fail = fail_q;

	// Bytes left before the page boundary
	assign room = 7'(`EE_PAGE_BYTES) - {1'b0, cmd_addr[5:0]};
	assign tick = (div_q == 8'(SCL_QTR - 1));

	// Quarter-period divider for the serial clock we drive
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= 8'h00;
			s1_q <= 1'b1;
			s2_q <= 1'b1;
		end else begin
			div_q <= tick ? 8'h00 : div_q + 8'h01;
			s1_q <= link.sda;
			s2_q <= s1_q;
		end
	end

	// Each bit: clock low, set data, clock high, sample
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= h_idle;
			q_q <= 2'h0;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			left_q <= 7'h00;
			rdph_q <= 1'b0;
			poll_q <= 8'h00;
			scl_q <= 1'b1;
			oe_q <= 1'b0;
			dev_q <= 3'h0;
			addr_q <= 15'h0000;
			rdy_q <= 1'b1;
			rdv_q <= 1'b0;
			rdd_q <= 8'h00;
			done_q <= 1'b0;
			fail_q <= 1'b0;
		end else begin
			rdv_q <= 1'b0;
			done_q <= 1'b0;
			case (st_q)
				h_idle: if (cmd_valid) begin
					rdy_q <= 1'b0;
					dev_q <= cmd_dev;
					addr_q <= cmd_addr;
					// Never let one write command cross a page
					left_q <= (cmd_read || cmd_len <= room) ? cmd_len : room;
					rdph_q <= cmd_read && cmd_current;
					poll_q <= 8'h00;
					fail_q <= 1'b0;
					q_q <= 2'h0;
					st_q <= h_start;
				end
				h_load: if (f_valid) begin
					sh_q <= f_data;
					bit_q <= 4'h0;
					q_q <= 2'h0;
					st_q <= h_wr;
				end
				default: if (tick) begin
					q_q <= q_q + 2'h1;
					case (q_q)
						2'h0: scl_q <= 1'b0;
						2'h1: begin
							if (st_q == h_start) oe_q <= 1'b0;
							else if (st_q == h_stop) oe_q <= 1'b1;
							else if (bit_q != `EE_ACK_BIT) oe_q <= (st_q != h_rd) && !sh_q[7];
							else oe_q <= (st_q == h_rd) && (left_q != 7'h01);
						end
						2'h2: scl_q <= 1'b1;
						default: begin
							if (st_q == h_start) begin
								oe_q <= 1'b1;
								sh_q <= {`EE_TYPE_CODE, dev_q, rdph_q};
								bit_q <= 4'h0;
								st_q <= rdph_q ? h_rctrl : h_ctrl;
							end else if (st_q == h_stop) begin
								oe_q <= 1'b0;
								done_q <= 1'b1;
								rdy_q <= 1'b1;
								st_q <= h_idle;
							end else if (bit_q != `EE_ACK_BIT) begin
								sh_q <= {sh_q[6:0], s2_q};
								bit_q <= bit_q + 4'h1;
							end else begin
								bit_q <= 4'h0;
								case (st_q)
									h_ctrl: if (!s2_q) begin
										sh_q <= {1'b0, addr_q[14:8]};
										st_q <= h_ah;
									end else if (poll_q == 8'(POLL_MAX)) begin
										fail_q <= 1'b1;
										st_q <= h_stop;
									end else begin
										// Busy device: send Start and control again
										poll_q <= poll_q + 8'h01;
										st_q <= h_start;
									end
									h_ah: begin
										sh_q <= addr_q[7:0];
										st_q <= h_al;
									end
									h_al: if (left_q == 7'h00) begin
										st_q <= h_stop;
									end else if (rd_cmd_q && !rdph_q) begin
										// Turn round: the repeated Start carries the read bit
										rdph_q <= 1'b1;
										st_q <= h_start;
									end else begin
										st_q <= h_load;
									end
									h_wr: begin
										left_q <= left_q - 7'h01;
										st_q <= (left_q == 7'h01) ? h_stop : h_load;
									end
									h_rctrl: if (s2_q) begin
										fail_q <= 1'b1;
										st_q <= h_stop;
									end else begin
										st_q <= h_rd;
									end
									default: begin
										rdd_q <= sh_q;
										rdv_q <= 1'b1;
										left_q <= left_q - 7'h01;
										st_q <= (left_q == 7'h01) ? h_stop : h_rd;
									end
								endcase
							end
						end
					endcase
				end
			endcase
		end
	end

	// Random read: after the address, turn round with a repeated Start
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) rd_cmd_q <= 1'b0;
		else if (st_q == h_idle && cmd_valid) rd_cmd_q <= cmd_read;
	end
endmodule : eeprom_host

// [tb/link_monitor.sv]
`timescale 1ns/100ps
module link_monitor #(
	parameter int WR_CYCLES = 50
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic s_sda_o,
	input wire logic s_sda_oe,
	input wire logic write_protect,
	input wire logic write_busy
);
	localparam int BUSY_LEN = 64 + WR_CYCLES;
	logic scl_q, sda_q;
	logic [3:0] stop_age_q;
	logic [16:0] busy_cnt_q;

	// Previous bus sample, for edge detection
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	// Cycles since the last Stop, saturating so it never wraps back to fresh
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			stop_age_q <= 4'hF;
		end else if (scl && scl_q && sda && !sda_q) begin
			stop_age_q <= 4'h0;
		end else if (stop_age_q != 4'hF) begin
			stop_age_q <= stop_age_q + 4'h1;
		end
	end

	// Length of the current write cycle
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			busy_cnt_q <= 17'h00000;
		end else if (write_busy) begin
			busy_cnt_q <= busy_cnt_q + 17'h00001;
		end else begin
			busy_cnt_q <= 17'h00000;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence

	property p_quiet_busy;
		write_busy |-> !s_sda_oe;
	endproperty
	property p_busy_len;
		$fell(write_busy) |-> busy_cnt_q == BUSY_LEN;
	endproperty
	property p_busy_cause;
		$rose(write_busy) |-> stop_age_q < 4'h8;
	endproperty
	property p_wp_block;
		$rose(write_busy) |-> !$past(write_protect, 3);
	endproperty
	property p_wp_late;
		write_busy && $changed(write_protect) |=> write_busy;
	endproperty
	property p_change_low;
		$changed(s_sda_oe) |-> !scl;
	endproperty
	property p_quiet_stop;
		s_stop |=> !s_sda_oe [*8];
	endproperty
	property p_quiet_ctrl;
		s_start |-> !s_sda_oe [*8];
	endproperty

	a_quiet_busy: assert property (p_quiet_busy) else $error("device pulled data during write cycle");
	a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
	a_busy_cause: assert property (p_busy_cause) else $error("write cycle without recent stop");
	a_wp_block: assert property (p_wp_block) else $error("write cycle while protected");
	a_wp_late: assert property (p_wp_late) else $error("protect change cut write cycle");
	a_change_low: assert property (p_change_low) else $error("device changed data with clock high");
	a_quiet_stop: assert property (p_quiet_stop) else $error("device held data after stop");
	a_quiet_ctrl: assert property (p_quiet_ctrl) else $error("device pulled data in control byte");
endmodule : link_monitor

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
	localparam int WR_CYCLES = 50;
	localparam int CEILING = 40000;
	logic clk_sys, reset_n, cmd_valid, cmd_ready, cmd_read, cmd_current;
	logic wr_valid, wr_ready, rd_valid, done, fail, wp, write_busy;
	logic [2:0] cmd_dev, sel;
	logic [14:0] cmd_addr;
	logic [6:0] cmd_len;
	logic [7:0] wr_data, rd_data;
	logic [7:0] rdq[$];
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;

	eeprom_link_if link ();
	eeprom_host #(.SCL_QTR(3), .POLL_MAX(6), .FIFO_DEPTH(8)) eeprom_host_inst (.clk_sys(clk_sys),
		.reset_n(reset_n), .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
		.cmd_current(cmd_current), .cmd_dev(cmd_dev), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
		.rd_data(rd_data), .done(done), .fail(fail));
	eeprom_device #(.WR_CYCLES(WR_CYCLES)) eeprom_device_inst (.clk_sys(clk_sys), .reset_n(reset_n),
		.link(link), .select_pin_low(sel[0]), .select_pin_mid(sel[1]), .select_pin_high(sel[2]),
		.write_protect(wp), .write_busy(write_busy));
	link_monitor #(.WR_CYCLES(WR_CYCLES)) link_monitor_inst (.clk_sys(clk_sys), .reset_n(reset_n),
		.scl(link.scl), .sda(link.sda), .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe),
		.s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe), .write_protect(wp), .write_busy(write_busy));

	// 25 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Read bytes land here; rd_valid is a one-cycle pulse, taken mid-cycle
	always @(negedge clk_sys) begin
		if (rd_valid === 1'b1) rdq.push_back(rd_data);
	end

	// Hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == CEILING) begin
			n_mismatch++;
			$display("[ERR] %0t cycle ceiling reached", $time);
			conclude();
		end
	end

	task chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t byte %h expected %h", $time, got, exp);
		end
	endtask : chk8

	task chk1(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk1

	task rdchk(input logic [7:0] exp);
		logic [7:0] got;
		got = (rdq.size() > 0) ? rdq.pop_front() : 'x;
		chk8(got, exp);
	endtask : rdchk

	// One byte offered to the write FIFO for one cycle, not waited on; lost if the FIFO is full
	task push(input logic [7:0] d);
		@(negedge clk_sys);
		wr_valid = 1'b1;
		wr_data = d;
		@(negedge clk_sys);
		wr_valid = 1'b0;
	endtask : push

	// One command, waited to its done pulse, then the fail flag checked
	task run(input logic rd, input logic cur, input logic [2:0] dv, input logic [14:0] a,
		input logic [6:0] n, input logic ef);
		if (rd) begin
			// Current-address reads are not polled: let a write cycle begun at the last Stop run out
			repeat (6) @(negedge clk_sys);
			while (write_busy !== 1'b0) @(negedge clk_sys);
		end
		@(negedge clk_sys);
		cmd_valid = 1'b1;
		cmd_read = rd;
		cmd_current = cur;
		cmd_dev = dv;
		cmd_addr = a;
		cmd_len = n;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		do @(negedge clk_sys); while (done !== 1'b1);
		chk1(cmd_ready, 1'b1);
		chk1(fail, ef);
	endtask : run

	task wb(input logic [14:0] a, input logic [7:0] d);
		push(d);
		run(1'b0, 1'b0, 3'h2, a, 7'h01, 1'b0);
	endtask : wb

	// Address-only write: no data byte, so no write cycle either
	task seta(input logic [14:0] a);
		run(1'b0, 1'b0, 3'h2, a, 7'h00, 1'b0);
	endtask : seta

	task rdn(input logic [6:0] n);
		rdq.delete();
		run(1'b1, 1'b1, 3'h2, 15'h0000, n, 1'b0);
	endtask : rdn

	task conclude;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude

	initial begin
		reset_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_read = 1'b0;
		cmd_current = 1'b0;
		cmd_dev = 3'h0;
		cmd_addr = 15'h0000;
		cmd_len = 7'h00;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		sel = 3'h2;
		wp = 1'b0;
		repeat (2) @(negedge clk_sys);
		reset_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		// Fill FIFO until it refuses, then page write drains it
		for (int i = 0; i < 8; i++) push(8'h10 + 8'(i));
		chk1(wr_ready, 1'b0);
		push(8'hFF);
		run(1'b0, 1'b0, 3'h2, 15'h0040, 7'h08, 1'b0);
		chk1(wr_ready, 1'b1);
		wb(15'h0048, 8'hA5);
		// Protect toggled mid-cycle must not disturb it
		repeat (12) @(negedge clk_sys);
		wp = 1'b1;
		repeat (20) @(negedge clk_sys);
		wp = 1'b0;
		wb(15'h0047, 8'hC3);
		rdn(7'h01);
		rdchk(8'hA5);
		seta(15'h0040);
		repeat (10) @(negedge clk_sys);
		chk1(write_busy, 1'b0);
		rdn(7'h09);
		for (int i = 0; i < 7; i++) rdchk(8'h10 + 8'(i));
		rdchk(8'hC3);
		rdchk(8'hA5);
		// Protected write: acked, skipped, no busy
		wp = 1'b1;
		wb(15'h0040, 8'hEE);
		repeat (10) @(negedge clk_sys);
		chk1(write_busy, 1'b0);
		wp = 1'b0;
		seta(15'h0040);
		rdn(7'h01);
		rdchk(8'h10);
		wb(15'h7FFF, 8'h77);
		wb(15'h0000, 8'h66);
		seta(15'h7FFF);
		rdn(7'h02);
		rdchk(8'h77);
		rdchk(8'h66);
		run(1'b0, 1'b0, 3'h5, 15'h0000, 7'h00, 1'b1);
		rdq.delete();
		run(1'b1, 1'b0, 3'h2, 15'h0041, 7'h01, 1'b0);
		rdchk(8'h11);
		rdn(7'h01);
		rdchk(8'h12);
		// Four bytes from offset 62: host stops at the page end, rest wait in the FIFO
		for (int i = 0; i < 4; i++) push(8'h21 + 8'(i));
		run(1'b0, 1'b0, 3'h2, 15'h007E, 7'h04, 1'b0);
		run(1'b0, 1'b0, 3'h2, 15'h0080, 7'h02, 1'b0);
		seta(15'h007E);
		rdn(7'h04);
		for (int i = 0; i < 4; i++) rdchk(8'h21 + 8'(i));
		conclude();
	end
endmodule : testbench
